// file: bckf_regbank.v
`timescale 1ns/100ps
`default_nettype none
`include "bckf_regs.vh"
module bckf_regbank (
  input  wire       mclk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  input  wire       cfg_load,
  input  wire       cfg_range,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output reg  [5:0] normal_setpoint_field,
  output reg  [5:0] standby_setpoint,
  output reg  [5:0] sleep_setpoint,
  output reg        range_select,
  output reg  [3:0] switching_mode,
  output reg        sleep_state_select,
  output reg        current_limit_select,
  output reg  [1:0] switching_frequency_select,
  output reg  [1:0] phase_clock_select,
  output reg  [1:0] voltage_ramp_speed_select
);
  reg        range_q;
  reg [3:0]  mode_q;
  reg        sleep_q;
  reg [7:0]  conf_q;
  wire [7:0] normal_v;
  wire [7:0] standby_v;
  wire [7:0] sleep_v;
  reg  [7:0] rd_d;

  // range only changes by configuration load, one value shared by all three
  always @(posedge mclk) begin
    if (rst)
      range_q <= 1'b0;
    else if (cfg_load)
      range_q <= cfg_range;
  end

  bckf_sp_reg #(.ADDR(`BCKF_ADDR_NORMAL)) u_normal (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (wr_en),
    .wr_addr   (addr),
    .wr_data   (wr_data),
    .range_bit (range_q),
    .value     (normal_v)
  );
  bckf_sp_reg #(.ADDR(`BCKF_ADDR_STANDBY)) u_standby (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (wr_en),
    .wr_addr   (addr),
    .wr_data   (wr_data),
    .range_bit (range_q),
    .value     (standby_v)
  );
  bckf_sp_reg #(.ADDR(`BCKF_ADDR_SLEEP)) u_sleep (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (wr_en),
    .wr_addr   (addr),
    .wr_data   (wr_data),
    .range_bit (range_q),
    .value     (sleep_v)
  );

  always @(posedge mclk) begin
    if (rst) begin
      mode_q  <= `BCKF_MODE_RST;
      sleep_q <= 1'b0;
      conf_q  <= `BCKF_CONF_RST;
    end else if (wr_en) begin
      if (addr == `BCKF_ADDR_MODE) begin
        mode_q  <= wr_data[`BCKF_MODE_MSB:0];
        sleep_q <= wr_data[`BCKF_SLEEP_BIT];
      end
      // all eight bits stored, unused bit 1 included
      if (addr == `BCKF_ADDR_CONF)
        conf_q <= wr_data;
    end
  end

  always @* begin
    case (addr)
      `BCKF_ADDR_NORMAL:  rd_d = normal_v;
      `BCKF_ADDR_STANDBY: rd_d = standby_v;
      `BCKF_ADDR_SLEEP:   rd_d = sleep_v;
      `BCKF_ADDR_MODE:    rd_d = {2'b00, sleep_q, 1'b0, mode_q};
      `BCKF_ADDR_CONF:    rd_d = conf_q;
      default:            rd_d = 8'h00;
    endcase
  end

  // registered outputs: one cycle after each change
  always @(posedge mclk) begin
    if (rst) begin
      rd_data                    <= 8'h00;
      rd_valid                   <= 1'b0;
      normal_setpoint_field      <= `BCKF_SP_RST;
      standby_setpoint           <= `BCKF_SP_RST;
      sleep_setpoint             <= `BCKF_SP_RST;
      range_select               <= 1'b0;
      switching_mode             <= `BCKF_MODE_RST;
      sleep_state_select         <= 1'b0;
      current_limit_select       <= 1'b0;
      switching_frequency_select <= 2'h0;
      phase_clock_select         <= 2'h0;
      voltage_ramp_speed_select  <= 2'h0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_d;
      normal_setpoint_field      <= normal_v[`BCKF_SP_MSB:0];
      standby_setpoint           <= standby_v[`BCKF_SP_MSB:0];
      sleep_setpoint             <= sleep_v[`BCKF_SP_MSB:0];
      range_select               <= range_q;
      switching_mode             <= mode_q;
      sleep_state_select         <= sleep_q;
      current_limit_select       <= conf_q[`BCKF_ILIM_BIT];
      switching_frequency_select <= conf_q[`BCKF_FREQ_LSB+1:`BCKF_FREQ_LSB];
      phase_clock_select         <= conf_q[`BCKF_PHASE_LSB+1:`BCKF_PHASE_LSB];
      voltage_ramp_speed_select  <= conf_q[`BCKF_RAMP_LSB+1:`BCKF_RAMP_LSB];
    end
  end
endmodule
`default_nettype wire

// file: bckf_regs.vh
// Notes on behaviour
// - normal set-point at 0x4A, bits 5:0
// - normal range bit 6 read-only, set by configuration
// - standby set-point at 0x4B, bits 5:0
// - standby range bit copies configured normal range
// - sleep set-point at 0x4C, bits 5:0
// - sleep range bit copies configured normal range
// - switching mode 0x4D bits 3:0, reset 0x08
// - mode bit 5 sleep state, off or pfm
// - configuration 0x4E bit 0 current limit
// - configuration bits 3:2 switching frequency
// - configuration bits 5:4 phase clock select
// - configuration bits 7:6 voltage ramp speed
// - all control through serial register accesses, except range, set by configuration load
`ifndef BCKF_REGS_VH
`define BCKF_REGS_VH
`define BCKF_ADDR_NORMAL   8'h4A
`define BCKF_ADDR_STANDBY  8'h4B
`define BCKF_ADDR_SLEEP    8'h4C
`define BCKF_ADDR_MODE     8'h4D
`define BCKF_ADDR_CONF     8'h4E
`define BCKF_SP_MSB        5
`define BCKF_RANGE_BIT     6
`define BCKF_MODE_MSB      3
`define BCKF_SLEEP_BIT     5
`define BCKF_ILIM_BIT      0
`define BCKF_UNUSED_BIT    1
`define BCKF_FREQ_LSB      2
`define BCKF_PHASE_LSB     4
`define BCKF_RAMP_LSB      6
`define BCKF_SP_RST        6'h00
`define BCKF_MODE_RST      4'h8
`define BCKF_CONF_RST      8'h00
`endif

// file: bckf_sp_reg.v
`timescale 1ns/100ps
`default_nettype none
`include "bckf_regs.vh"
// one set-point register: 6 writable code bits, range bit from configuration
module bckf_sp_reg #(
  parameter [7:0] ADDR = 8'h00
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire       range_bit,
  output wire [7:0] value
);
  reg [5:0] code_q;
  always @(posedge mclk) begin
    if (rst)
      code_q <= `BCKF_SP_RST;
    else if (wr_en && wr_addr == ADDR)
      code_q <= wr_data[`BCKF_SP_MSB:0];
  end
  // bit 7 held at zero, bit 6 never written by host
  assign value = {1'b0, range_bit, code_q};
endmodule
`default_nettype wire

// file: bckf_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bckf_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic [5:0] normal_setpoint_field,
  input wire logic [3:0] switching_mode,
  input wire logic       range_select,
  input wire logic       cfg_load
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_valid_on_read: assert property (rd_en |=> rd_valid)
    else $error("no rd_valid");
  a_valid_no_read: assert property (!rd_en |=> !rd_valid)
    else $error("stray rd_valid");
  a_normal_write: assert property (wr_en && addr == 8'h4A |=> ##1
    normal_setpoint_field == $past(wr_data[5:0], 2)) else $error("normal");
  a_mode_write: assert property (wr_en && addr == 8'h4D |=> ##1
    switching_mode == $past(wr_data[3:0], 2)) else $error("mode");
  // range_select trails cfg_load by two flops, so three quiet cycles suffice; the check waits four
  a_range_held: assert property (!cfg_load [*4] |->
    $stable(range_select)) else $error("range moved");
  a_unmapped_zero: assert property (rd_en && (addr < 8'h4A ||
    addr > 8'h4E) |=> rd_data == 8'h00) else $error("unmapped");
  a_sp_top_zero: assert property (rd_en && addr inside {[8'h4A:8'h4C]}
    |=> !rd_data[7]) else $error("bit 7");
  a_mode_read: assert property (rd_en && addr == 8'h4D |=>
    rd_data[3:0] == switching_mode) else $error("mode read");
endmodule
bind bckf_regbank bckf_checker u_chk (.mclk, .rst, .wr_en, .rd_en, .addr,
  .wr_data, .rd_data, .rd_valid, .normal_setpoint_field, .switching_mode,
  .range_select, .cfg_load);
`default_nettype wire

// file: bckf_host.sv
`timescale 1ns/100ps
`default_nettype none
module bckf_host (
  input  wire logic       mclk,
  input  wire logic [7:0] rd_data,
  output var  logic       wr_en,
  output var  logic       rd_en,
  output var  logic [7:0] addr,
  output var  logic [7:0] wr_data
);
  initial {wr_en, rd_en, addr, wr_data} = 18'h0;
  // released address and data inverted and enables cleared, so stale values are not mistaken for held ones
  task automatic acc(input logic w, input logic [7:0] a, d,
    output logic [7:0] q);
    @(posedge mclk);
    {wr_en, rd_en, addr, wr_data} <= {w, !w, a, d};
    @(posedge mclk);
    {wr_en, rd_en, addr, wr_data} <= {2'b00, ~a, ~d};
    #1 q = rd_data;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        mclk = 1'b0, rst = 1'b1, cl = 1'b0, cr = 1'b0;
  logic [7:0]  q;
  wire  [7:0]  addr, wr_data, rd_data;
  wire         wr_en, rd_en, rs, ss, il, rv;
  wire  [5:0]  ns, sb, sl;
  wire  [3:0]  sm;
  wire  [1:0]  fq, ph, rp;
  int          errors = 0, compares = 0;
  // address, write data, reset value, read back
  logic [31:0] rows [6] = '{32'h4AFF003F, 32'h4BC50005, 32'h4C2A002A,
    32'h4DFF082F, 32'h4EA500A5, 32'h50FF0000};
  always #5 mclk = ~mclk;
  bckf_host h (.mclk, .rd_data, .wr_en, .rd_en, .addr, .wr_data);
  bckf_regbank DUT (.mclk, .rst, .wr_en, .rd_en, .addr, .wr_data,
    .cfg_load(cl), .cfg_range(cr), .rd_data, .rd_valid(rv),
    .normal_setpoint_field(ns), .standby_setpoint(sb), .sleep_setpoint(sl),
    .range_select(rs), .switching_mode(sm), .sleep_state_select(ss),
    .current_limit_select(il), .switching_frequency_select(fq),
    .phase_clock_select(ph), .voltage_ramp_speed_select(rp));
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000 errors++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      h.acc(0, rows[i][31:24], 8'h00, q);
      chk("reset", rows[i][15:8], q);
      h.acc(1, rows[i][31:24], rows[i][23:16], q);
      h.acc(0, rows[i][31:24], 8'h00, q);
      chk("read", rows[i][7:0], q);
    end
    chk("sp", 16'hFC5A, {ns, sb, sl[3:0]});
    chk("sleep", 16'h2A, {2'b00, sl});
    chk("mode", 16'h1F, {ss, sm});
    chk("conf", 16'h53, {rp, ph, fq, il});
    @(posedge mclk) {cl, cr} <= 2'b11;
    @(posedge mclk) cl <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      h.acc(0, rows[i][31:24], 8'h00, q);
      chk("range", rows[i][7:0] | 8'h40, q);
    end
    // range bit must survive a write of zero
    h.acc(1, 8'h4A, 8'h00, q);
    h.acc(0, 8'h4A, 8'h00, q);
    chk("range keep", 16'h40, q);
    // mid-run reset: every field output except sleep_setpoint and standby_setpoint bits 5:4 checked back at its reset value
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk("rst fields", 16'h0008, {rs, ns, sb[3:0], sm});
    chk("rst valid", 16'h0, {15'h0, rv});
    chk("rst conf", 16'h0, {ss, rp, ph, fq, il});
    h.acc(0, 8'h4D, 8'h00, q);
    chk("rst mode rd", 16'h08, q);
    end_of_test;
  end
endmodule
`default_nettype wire
